// ---- rtl/icp_pkg.sv ----
// shared constants for the interrupt channel prioritizer
package icp_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_CHAN = 64;           // request channels
    localparam int CHAN_W = 6;              // channel number width
    localparam int ADDR_W = 10;             // register address width
    localparam int DATA_W = 32;             // register data width

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [9:0] OFS_ENABLE_LO = 10'h000;
    localparam logic [9:0] OFS_ENABLE_HI = 10'h004;
    localparam logic [9:0] OFS_FAST_LO = 10'h008;
    localparam logic [9:0] OFS_FAST_HI = 10'h00c;
    localparam logic [9:0] OFS_RAW_LO = 10'h010;
    localparam logic [9:0] OFS_RAW_HI = 10'h014;
    localparam logic [9:0] OFS_PEND_LO = 10'h018;
    localparam logic [9:0] OFS_PEND_HI = 10'h01c;
    localparam logic [9:0] OFS_ACTIVE = 10'h020;
    localparam logic [1:0] MAP_PAGE = 2'h1;  // address bits 9:8 of map words

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [63:0] NMI_CHANS = 64'h0000_0000_0000_0003;
    localparam logic [63:0] RST_ENABLE = 64'h0000_0000_0000_0003;
    localparam logic [63:0] RST_FAST = 64'h0000_0000_0000_0000;
    localparam int ST_FAST_VLD = 8;         // active register fields
    localparam int ST_NORM_LSB = 16;
    localparam int ST_NORM_VLD = 24;

    // ------------------------------------------------------------
    // default channel of each source slot
    // ------------------------------------------------------------
    localparam int CH_ERR_HIGH = 0;
    localparam int CH_NMI_RSVD = 1;
    localparam int CH_OS_CMP0 = 2;
    localparam int CH_OS_CMP3 = 5;
    localparam int CH_OS_OVF0 = 6;
    localparam int CH_OS_OVF1 = 7;
    localparam int CH_OS_TBASE = 8;
    localparam int CH_HET_L1 = 10;
    localparam int CH_HTU_L1 = 11;
    localparam int CH_BSP1_L0 = 12;
    localparam int CH_LSP1_L0 = 13;
    localparam int CH_CNV1_EVT = 14;
    localparam int CH_CNV1_SW1 = 15;
    localparam int CH_CAN1_L0 = 16;
    localparam int CH_TTB_L0 = 18;
    localparam int CH_CHKSUM = 19;
    localparam int CH_ERR_LOW = 20;
    localparam int CH_SYS_SWI = 21;
    localparam int CH_PERF_MON = 22;
    localparam int CH_HET_L2 = 24;
    localparam int CH_HTU_L2 = 25;
    localparam int CH_BSP1_L1 = 26;
    localparam int CH_LSP1_L1 = 27;
    localparam int CH_CNV1_SW2 = 28;
    localparam int CH_CAN1_L1 = 29;
    localparam int CH_CNV1_MAG = 31;

    // source slot s is wired to the source whose default channel is s
    function automatic logic [5:0] default_chan(input int src);
        if (src == CH_ERR_HIGH || src == CH_NMI_RSVD) begin
            return src[5:0];
        end else if (src >= CH_OS_CMP0 && src <= CH_OS_CMP3) begin
            return src[5:0];
        end else if (src == CH_OS_OVF0 || src == CH_OS_OVF1 || src == CH_OS_TBASE) begin
            return src[5:0];
        end else if (src == CH_HET_L1 || src == CH_HET_L2) begin
            return src[5:0];
        end else if (src == CH_HTU_L1 || src == CH_HTU_L2) begin
            return src[5:0];
        end else if (src == CH_BSP1_L0 || src == CH_BSP1_L1) begin
            return src[5:0];
        end else if (src == CH_LSP1_L0 || src == CH_LSP1_L1) begin
            return src[5:0];
        end else if (src == CH_CNV1_EVT || src == CH_CNV1_SW1 ||
                     src == CH_CNV1_SW2 || src == CH_CNV1_MAG) begin
            return src[5:0];
        end else if (src == CH_CAN1_L0 || src == CH_CAN1_L1) begin
            return src[5:0];
        end else if (src == CH_TTB_L0 || src == CH_CHKSUM) begin
            return src[5:0];
        end else if (src == CH_ERR_LOW) begin
            return src[5:0];
        end else if (src == CH_SYS_SWI || src == CH_PERF_MON) begin
            return src[5:0];
        end
        return src[5:0];
    endfunction : default_chan

endpackage : icp_pkg

// ---- rtl/chmap_if.sv ----
// bundle between the controller and the source-to-channel map
interface chmap_if;
    logic we;               // map entry write
    logic [5:0] widx;       // source slot written
    logic [5:0] wdata;      // new channel number
    logic [5:0] ridx;       // source slot read back
    logic [5:0] rdata;      // channel number of ridx
    logic [63:0] src;       // raw source request lines
    logic [63:0] chan_req;  // combined per-channel requests
    modport ctrl (output we, widx, wdata, ridx, src, input rdata, chan_req);
    modport map (input we, widx, wdata, ridx, src, output rdata, chan_req);
endinterface : chmap_if

// ---- rtl/chan_map.sv ----
// source-to-channel map store and request combiner
module chan_map
    import icp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    chmap_if.map m
);

    // ------------------------------------------------------------
    // map entries, one per source slot
    // ------------------------------------------------------------
    logic [5:0] entry [NUM_CHAN];   // channel of each source

    genvar s;
    generate
        for (s = 0; s < NUM_CHAN; s++) begin : g_entry
            // reset loads the default assignment of this slot
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    entry[s] <= default_chan(s);
                end else if (m.we && m.widx == 6'(s)) begin
                    entry[s] <= m.wdata;
                end
            end
        end
    endgenerate

    // read port for register readback
    assign m.rdata = entry[m.ridx];

    // ------------------------------------------------------------
    // combine: any source on a channel raises it
    // ------------------------------------------------------------
    always_comb begin
        m.chan_req = '0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (m.src[i]) begin
                m.chan_req[entry[i]] = 1'b1;
            end
        end
    end

endmodule : chan_map

// ---- rtl/prio_pick.sv ----
// finds the lowest-numbered set bit of a request vector
module prio_pick
    import icp_pkg::*;
(
    input wire logic [63:0] req,
    output logic any,
    output logic [5:0] idx
);

    // scan downward so the lowest channel is written last and wins
    always_comb begin
        idx = '0;
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 6'(i);
            end
        end
        any = |req;
    end

endmodule : prio_pick

// ---- rtl/irq_prioritizer.sv ----
// top of the 64-channel interrupt prioritizer
//
// What this block does
// - sixty-four channels; every source routes to one
// - sources sharing a channel are OR-combined
// - per-channel mask blocks forwarding to processor
// - each channel typed fast or normal
// - lower channel number wins over higher
// - high error on 0; channels 0 and 1 non-maskable
// - os timer compares 2-5, overflows 6-7, timebase 8
// - high-end timer levels on 10 and 24
// - transfer unit levels on 11 and 25
// - serial port one levels on 12, 26
// - local serial port levels on 13, 27
// - converter one on 14, 15, 28, 31
// - can one on 16, 29; 17, 30 reserved
// - time-triggered bus 18, checksum unit 19
// - low error on 20, below channel 0
// - software interrupt 21, performance monitor 22
module irq_prioritizer
    import icp_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [63:0] SRC_REQ,
    input wire logic [9:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [31:0] RDATA,
    output logic FAST_REQ,
    output logic [5:0] FAST_CHAN,
    output logic NORM_REQ,
    output logic [5:0] NORM_CHAN
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // map words sit on one page, one aligned word per source slot
    function automatic logic is_map(input logic [9:0] a);
        return (a[9:8] == MAP_PAGE) && (a[1:0] == 2'h0);
    endfunction : is_map

    // all channels numbered below idx
    function automatic logic [63:0] below(input logic [5:0] idx);
        return (64'h1 << idx) - 64'h1;
    endfunction : below

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [63:0] enable;        // channel enables, 1 forwards
    logic [63:0] fast_sel;      // channel type, 1 is fast
    logic [63:0] raw;           // combined channel requests
    logic [63:0] pend;          // requests that pass the mask
    logic [63:0] fast_pend;     // pending and typed fast
    logic [63:0] norm_pend;     // pending and typed normal
    logic fast_any;             // some fast channel pending
    logic norm_any;             // some normal channel pending
    logic [5:0] fast_idx;       // winning fast channel
    logic [5:0] norm_idx;       // winning normal channel

    chmap_if mif ();

    // ------------------------------------------------------------
    // source map
    // ------------------------------------------------------------
    // map writes land on the slot taken from address bits 7:2
    assign mif.we = WR_STB && is_map(ADDR);
    assign mif.widx = ADDR[7:2];
    assign mif.wdata = WDATA[5:0];
    assign mif.ridx = ADDR[7:2];
    assign mif.src = SRC_REQ;

    chan_map u_map (
        .clk (CLK_SYS),
        .rst_n (RSTN),
        .m (mif.map)
    );

    assign raw = mif.chan_req;

    // ------------------------------------------------------------
    // enable and type registers
    // ------------------------------------------------------------
    // the two non-maskable channels stay enabled whatever is written
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            enable <= RST_ENABLE;
        end else if (WR_STB && ADDR == OFS_ENABLE_LO) begin
            enable[31:0] <= WDATA | NMI_CHANS[31:0];
        end else if (WR_STB && ADDR == OFS_ENABLE_HI) begin
            enable[63:32] <= WDATA | NMI_CHANS[63:32];
        end
    end

    // fast or normal delivery per channel
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            fast_sel <= RST_FAST;
        end else if (WR_STB && ADDR == OFS_FAST_LO) begin
            fast_sel[31:0] <= WDATA;
        end else if (WR_STB && ADDR == OFS_FAST_HI) begin
            fast_sel[63:32] <= WDATA;
        end
    end

    // ------------------------------------------------------------
    // masking and typing
    // ------------------------------------------------------------
    // requests are levels, never latched: a masked source that is
    // still high shows up again the cycle its enable returns
    assign pend = raw & enable;
    assign fast_pend = pend & fast_sel;
    assign norm_pend = pend & ~fast_sel;

    prio_pick u_fast (
        .req (fast_pend),
        .any (fast_any),
        .idx (fast_idx)
    );

    prio_pick u_norm (
        .req (norm_pend),
        .any (norm_any),
        .idx (norm_idx)
    );

    // ------------------------------------------------------------
    // processor request outputs
    // ------------------------------------------------------------
    // registered so the core sees glitch-free levels; costs a cycle
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            FAST_REQ <= 1'b0;
            FAST_CHAN <= '0;
        end else begin
            FAST_REQ <= fast_any;
            FAST_CHAN <= fast_idx;
        end
    end

    // normal request path, same timing as the fast one
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            NORM_REQ <= 1'b0;
            NORM_CHAN <= '0;
        end else begin
            NORM_REQ <= norm_any;
            NORM_CHAN <= norm_idx;
        end
    end

    // ------------------------------------------------------------
    // register readback
    // ------------------------------------------------------------
    // data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= '0;
        end else if (!RD_STB) begin
            RDATA <= '0;
        end else if (ADDR == OFS_ENABLE_LO) begin
            RDATA <= enable[31:0];
        end else if (ADDR == OFS_ENABLE_HI) begin
            RDATA <= enable[63:32];
        end else if (ADDR == OFS_FAST_LO) begin
            RDATA <= fast_sel[31:0];
        end else if (ADDR == OFS_FAST_HI) begin
            RDATA <= fast_sel[63:32];
        end else if (ADDR == OFS_RAW_LO) begin
            RDATA <= raw[31:0];
        end else if (ADDR == OFS_RAW_HI) begin
            RDATA <= raw[63:32];
        end else if (ADDR == OFS_PEND_LO) begin
            RDATA <= pend[31:0];
        end else if (ADDR == OFS_PEND_HI) begin
            RDATA <= pend[63:32];
        end else if (ADDR == OFS_ACTIVE) begin
            // shows what the outputs will carry next cycle
            RDATA <= {7'h0, norm_any, 2'h0, norm_idx,
                      7'h0, fast_any, 2'h0, fast_idx};
        end else if (is_map(ADDR)) begin
            RDATA <= {26'h0, mif.rdata};
        end else begin
            // unmapped addresses read as zero
            RDATA <= '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);

    // fast output follows pending fast channels one cycle later
    a_fast_follows: assert property (
        ##1 FAST_REQ == $past(fast_any))
        else $error("fast request does not follow pending set");

    // nothing pending means the normal request drops next cycle
    a_norm_drops: assert property (
        !norm_any |=> !NORM_REQ)
        else $error("normal request held with nothing pending");

    // no lower fast channel was pending than the one shown
    a_fast_lowest: assert property (
        FAST_REQ |-> ($past(fast_pend) & below(FAST_CHAN)) == 64'h0)
        else $error("fast channel is not the lowest pending");

    // no lower normal channel was pending than the one shown
    a_norm_lowest: assert property (
        NORM_REQ |-> ($past(norm_pend) & below(NORM_CHAN)) == 64'h0)
        else $error("normal channel is not the lowest pending");

    // the fast winner really was typed fast; the index is the one shown now,
    // not the one shown a cycle earlier
    a_fast_typed: assert property (
        FAST_REQ |-> ($past(fast_sel) & (64'h1 << FAST_CHAN)) != 64'h0)
        else $error("fast output carries a normal channel");

    // a masked channel never reaches the normal output
    a_norm_masked: assert property (
        NORM_REQ |-> ($past(enable) & $past(raw) & (64'h1 << NORM_CHAN)) != 64'h0)
        else $error("normal output carries a masked channel");

    // a write to the low enable word takes effect next cycle
    a_enable_write: assert property (
        WR_STB && ADDR == OFS_ENABLE_LO
        |=> enable[31:0] == ($past(WDATA) | NMI_CHANS[31:0]))
        else $error("enable write not applied");

    // non-maskable channels stay enabled at all times
    a_nmi_unmasked: assert property (
        enable[1:0] == 2'h3)
        else $error("non-maskable channel got masked");

    // raw request readback comes one cycle after the strobe
    a_raw_readback: assert property (
        RD_STB && ADDR == OFS_RAW_LO |=> RDATA == $past(raw[31:0]))
        else $error("raw request readback wrong");

    // a still-high source returns two cycles after re-enable
    a_reenable: assert property (
        WR_STB && ADDR == OFS_ENABLE_LO && WDATA[2] && !fast_sel[2]
        ##1 raw[2] && norm_pend[1:0] == 2'h0 |=> NORM_REQ)
        else $error("re-enabled channel not presented");

    // normal output follows pending normal channels one cycle later
    a_norm_follows: assert property (
        ##1 NORM_REQ == $past(norm_any))
        else $error("normal request does not follow pending set");

    // nothing fast pending means the fast request drops next cycle
    a_fast_drops: assert property (
        !fast_any |=> !FAST_REQ)
        else $error("fast request held with nothing pending");

    // the normal winner really was typed normal
    a_norm_typed: assert property (
        NORM_REQ |-> ($past(fast_sel) & (64'h1 << NORM_CHAN)) == 64'h0)
        else $error("normal output carries a fast channel");

    // a masked channel never reaches the fast output
    a_fast_masked: assert property (
        FAST_REQ |-> ($past(pend) & (64'h1 << FAST_CHAN)) != 64'h0)
        else $error("fast output carries a masked channel");

    // a write to the high enable word takes effect next cycle
    a_enable_hi: assert property (
        WR_STB && ADDR == OFS_ENABLE_HI
        |=> enable[63:32] == ($past(WDATA) | NMI_CHANS[63:32]))
        else $error("high enable write not applied");

    // a write to the high type word takes effect next cycle
    a_fast_hi: assert property (
        WR_STB && ADDR == OFS_FAST_HI |=> fast_sel[63:32] == $past(WDATA))
        else $error("high type write not applied");

    // pending readback shows only channels that pass the mask
    a_pend_readback: assert property (
        RD_STB && ADDR == OFS_PEND_LO |=> RDATA == $past(pend[31:0]))
        else $error("pending readback wrong");

    // map readback returns the channel of the addressed slot
    a_map_readback: assert property (
        RD_STB && is_map(ADDR) |=> RDATA == {26'h0, $past(mif.rdata)})
        else $error("map readback wrong");

    // with no channel requested both outputs are quiet next cycle
    a_idle_quiet: assert property (
        raw == 64'h0 |=> !FAST_REQ && !NORM_REQ)
        else $error("request shown with no channel raised");

    c_fast_seen: cover property (FAST_REQ);
    c_norm_seen: cover property (NORM_REQ && NORM_CHAN != 6'h0);
    c_both_seen: cover property (FAST_REQ && NORM_REQ);
    c_map_write: cover property (mif.we ##1 raw != 64'h0);

endmodule : irq_prioritizer

// ---- testbench/core_src_model.sv ----
// peripheral request lines and processor core facing the prioritizer
module core_src_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic [63:0] src_req,
    input wire logic fast_req,
    input wire logic [5:0] fast_chan,
    input wire logic norm_req,
    input wire logic [5:0] norm_chan
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // peripheral side
    // ------------------------------------------------------------
    logic [63:0] level = 64'h0; // request levels held by the peripherals

    // peripherals hold their lines as plain levels until the bench drives new ones
    assign src_req = level;

    // change the source levels right after a rising edge
    task automatic drive(input logic [63:0] v);
        @(posedge clk);
        level <= v;
    endtask : drive

    // ------------------------------------------------------------
    // core side
    // ------------------------------------------------------------
    logic nmi_fast = 1'b0; // core-held choice: fast line taken as non-maskable
    logic [5:0] last_fast = 6'h0; // last fast channel the core saw
    logic [5:0] last_norm = 6'h0; // last normal channel the core saw

    // the core only records what it was offered; it never acknowledges,
    // because the prioritizer presents pure levels with no handshake
    always @(posedge clk) begin
        if (!rst_n) begin
            last_fast <= 6'h0;
            last_norm <= 6'h0;
        end else begin
            if (fast_req === 1'b1) begin
                last_fast <= fast_chan;
            end
            if (norm_req === 1'b1) begin
                last_norm <= norm_chan;
            end
        end
    end
endmodule : core_src_model

// ---- testbench/test_irq_prioritizer.sv ----
// self-checking bench for the interrupt channel prioritizer
module test_irq_prioritizer
    import icp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys; // 50 MHz system clock
    logic rst_n; // active low reset
    logic [63:0] src_req; // from the peripheral model
    logic [9:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wr_stb;
    logic rd_stb;
    logic fast_req;
    logic [5:0] fast_chan;
    logic norm_req;
    logic [5:0] norm_chan;
    int err_count = 0; // mismatches seen
    int checks = 0; // comparisons made

    irq_prioritizer irq_prioritizer_inst (
        .CLK_SYS(clk_sys), .RSTN(rst_n), .SRC_REQ(src_req), .ADDR(addr),
        .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
        .FAST_REQ(fast_req), .FAST_CHAN(fast_chan), .NORM_REQ(norm_req),
        .NORM_CHAN(norm_chan)
    );

    core_src_model core_src_model_inst (
        .clk(clk_sys), .rst_n(rst_n), .src_req(src_req), .fast_req(fast_req),
        .fast_chan(fast_chan), .norm_req(norm_req), .norm_chan(norm_chan)
    );

    // free-running clock, 20 ns period
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // helper tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask : wr

    // one-cycle read strobe; data stands only in the following cycle
    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    // let the edge after a change land, then look
    task automatic settle;
        @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic src(input logic [63:0] v);
        core_src_model_inst.drive(v);
        settle();
    endtask : src

    // request lines always compared; channel only while its line is up
    task automatic out_chk(input logic fr, input logic [5:0] fc, input logic nr,
                           input logic [5:0] nc);
        chk({31'h0, fast_req}, {31'h0, fr});
        chk({31'h0, norm_req}, {31'h0, nr});
        if (fr) begin
            chk({26'h0, fast_chan}, {26'h0, fc});
        end
        if (nr) begin
            chk({26'h0, norm_chan}, {26'h0, nc});
        end
    endtask : out_chk

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // hang guard: the sequence needs well under 2,000 cycles
    initial begin
        #100us;
        err_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        addr = 10'h0;
        wdata = 32'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle();
        // reset state and default map of every slot
        out_chk(1'b0, 6'h0, 1'b0, 6'h0);
        rd_chk(OFS_ENABLE_LO, 32'h0000_0003);
        rd_chk(OFS_ENABLE_HI, 32'h0000_0000);
        rd_chk(OFS_FAST_LO, 32'h0000_0000);
        for (int s = 0; s < NUM_CHAN; s++) begin
            rd_chk({MAP_PAGE, s[5:0], 2'b00}, {26'h0, s[5:0]});
        end
        // each default source in slots 0 to 31 lands on its own channel
        wr(OFS_ENABLE_LO, 32'hffff_ffff);
        for (int s = 0; s < 32; s++) begin
            src(64'h1 << s);
            out_chk(1'b0, 6'h0, 1'b1, s[5:0]);
            rd_chk(OFS_RAW_LO, 32'h1 << s);
        end
        // precedence falls as the channel number rises
        src(64'h0000_0000_0010_0001);
        out_chk(1'b0, 6'h0, 1'b1, 6'd0);
        wr(OFS_ENABLE_HI, 32'hffff_ffff);
        src(64'h8000_0100_0000_0020);
        out_chk(1'b0, 6'h0, 1'b1, 6'd5);
        src(64'h8000_0100_0000_0000);
        out_chk(1'b0, 6'h0, 1'b1, 6'd40);
        src(64'h0);
        out_chk(1'b0, 6'h0, 1'b0, 6'h0);
        // masking blocks forwarding; re-enabling presents the held source
        src(64'h0000_0100_0000_0000);
        wr(OFS_ENABLE_HI, 32'h0);
        settle();
        out_chk(1'b0, 6'h0, 1'b0, 6'h0);
        rd_chk(OFS_RAW_HI, 32'h0000_0100);
        rd_chk(OFS_PEND_HI, 32'h0);
        wr(OFS_ENABLE_HI, 32'h0000_0100);
        settle();
        out_chk(1'b0, 6'h0, 1'b1, 6'd40);
        // channels 0 and 1 cannot be disabled
        wr(OFS_ENABLE_LO, 32'h0);
        rd_chk(OFS_ENABLE_LO, 32'h0000_0003);
        src(64'h2);
        out_chk(1'b0, 6'h0, 1'b1, 6'd1);
        // fast and normal winners side by side
        wr(OFS_FAST_LO, 32'h0000_0020);
        wr(OFS_ENABLE_LO, 32'h0000_00ff);
        src(64'h0000_0000_0000_00a0);
        out_chk(1'b1, 6'd5, 1'b1, 6'd7);
        rd_chk(OFS_ACTIVE, 32'h0107_0105);
        // slot 33 moved onto channel 9 shares it with slot 9
        wr(OFS_FAST_LO, 32'h0);
        wr(OFS_ENABLE_LO, 32'h0000_0200);
        wr({MAP_PAGE, 6'd33, 2'b00}, 32'd9);
        rd_chk({MAP_PAGE, 6'd33, 2'b00}, 32'd9);
        src(64'h0000_0002_0000_0000);
        out_chk(1'b0, 6'h0, 1'b1, 6'd9);
        rd_chk(OFS_RAW_LO, 32'h0000_0200);
        src(64'h0000_0000_0000_0200);
        out_chk(1'b0, 6'h0, 1'b1, 6'd9);
        // a held source on a masked low channel returns on re-enable
        src(64'h0000_0000_0000_0004);
        out_chk(1'b0, 6'h0, 1'b0, 6'h0);
        wr(OFS_ENABLE_LO, 32'h0000_0004);
        settle();
        out_chk(1'b0, 6'h0, 1'b1, 6'd2);
        // a fast channel in the high word beside a normal one
        wr(OFS_FAST_HI, 32'h8000_0000);
        rd_chk(OFS_FAST_HI, 32'h8000_0000);
        wr(OFS_ENABLE_HI, 32'hffff_ffff);
        src(64'h8000_0000_0000_0004);
        out_chk(1'b1, 6'd63, 1'b1, 6'd2);
        rd_chk(OFS_PEND_LO, 32'h0000_0004);
        rd_chk(OFS_PEND_HI, 32'h8000_0000);
        chk({26'h0, core_src_model_inst.last_fast}, {26'h0, 6'd63});
        chk({26'h0, core_src_model_inst.last_norm}, {26'h0, 6'd2});
        src(64'h0);
        out_chk(1'b0, 6'h0, 1'b0, 6'h0);
        // unmapped read and a write to a read-only word
        rd_chk(10'h3fc, 32'h0);
        wr(OFS_RAW_LO, 32'hffff_ffff);
        rd_chk(OFS_RAW_LO, 32'h0);
        summarize();
    end
endmodule : test_irq_prioritizer
